// ==== verilog/ddh_defs.svh ====
`ifndef DDH_DEFS_SVH
`define DDH_DEFS_SVH
`define DDH_CLK_NS        50
`define DDH_TREFI_NS      7800
`define DDH_TREFI_HOT_NS  3900
`define DDH_TREFI_CYC     (`DDH_TREFI_NS / `DDH_CLK_NS)
`define DDH_TREFI_HOT_CYC (`DDH_TREFI_HOT_NS / `DDH_CLK_NS)
`define DDH_OFF_CTRL      8'h00
`define DDH_OFF_CMD       8'h04
`define DDH_OFF_ADDR      8'h08
`define DDH_OFF_MASK      8'h0c
`define DDH_OFF_STAT      8'h10
`define DDH_OFF_WDAT      4'h2
`define DDH_OFF_RDAT      4'h3
`define DDH_CTRL_RST      32'h0000_4004
`define DDH_F_CRD         2:0
`define DDH_F_PCD         6:4
`define DDH_F_BL8         8
`define DDH_F_ILV         9
`define DDH_F_TERM        12
`define DDH_F_HOT         13
`define DDH_F_REFEN       14
`define DDH_OP_ACT        4'h1
`define DDH_OP_RD         4'h2
`define DDH_OP_WR         4'h3
`define DDH_OP_PRE        4'h4
`define DDH_OP_REF        4'h5
`define DDH_OP_MRS        4'h6
`define DDH_OP_PD         4'h7
`define DDH_OP_SR         4'h8
`define DDH_OP_EXIT       4'h9
`define DDH_PIN_ACT       3'h3
`define DDH_PIN_RD        3'h5
`define DDH_PIN_WR        3'h4
`define DDH_PIN_PRE       3'h2
`define DDH_PIN_REF       3'h1
`define DDH_PIN_MRS       3'h0
`define DDH_PIN_NOP       3'h7
`define DDH_SCOPE_BIT     10
`endif

// ==== verilog/ddh_pkg.sv ====
package ddh_pkg;
   typedef struct packed {
      logic        clock_enable;
      logic        chip_select_n;
      logic [2:0]  strobes_n;
      logic [1:0]  bank_select;
      logic [12:0] addr;
      logic        termination_control;
   } ddh_pins_t;
   typedef enum logic [2:0] {
      S_IDLE, S_WLAT, S_WBURST, S_RLAT, S_RBURST, S_PDOWN, S_SREF
   } ddh_state_t;
endpackage : ddh_pkg

// ==== verilog/ddh_ctrl.sv ====
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ddh_defs.svh"
module ddh_ctrl (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [7:0]        s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   output logic                   diff_clock_pair_p,
   output logic                   diff_clock_pair_n,
   output ddh_pkg::ddh_pins_t     pins,
   output logic [15:0]            dq_o,
   output logic                   dq_oe,
   input  wire logic [15:0]       dq_i,
   output logic                   lower_byte_strobe_o,
   output logic                   upper_byte_strobe_o,
   output logic                   strobe_oe,
   input  wire logic              lower_byte_strobe_i,
   output logic [1:0]             write_byte_mask
);
   import ddh_pkg::*;

   logic [31:0] ctrl_reg, addr_reg, mask_reg;
   logic [3:0]  op_reg;
   logic        cmd_pend_reg;
   logic        aw_got_reg, w_got_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic [15:0] wbuf [8];
   logic [15:0] rbuf [8];
   logic [1:0]  phase_reg;
   ddh_state_t  state_reg;
   logic [3:0]  lat_reg;
   logic [3:0]  beat_reg;
   logic [3:0]  open_reg;
   logic [7:0]  ref_cnt_reg;
   logic        ref_pend_reg;
   logic        rd_done_reg;
   logic        ls_s1, ls_s2, ls_s3, ls_f;
   logic [15:0] dq_s1, dq_s2, dq_s3;
   logic        sr_issue_reg;

   wire        tick     = (phase_reg == 2'd3);
   wire        dat_tick = phase_reg[0];
   wire        stb_tick = ~phase_reg[0];
   wire [2:0]  column_read_delay    = ctrl_reg[`DDH_F_CRD];
   wire [2:0]  posted_command_delay = ctrl_reg[`DDH_F_PCD];
   wire [3:0]  read_delay  = {1'b0, column_read_delay} + {1'b0, posted_command_delay};
   wire [3:0]  write_delay = read_delay - 4'd1;
   wire [3:0]  burst_words = ctrl_reg[`DDH_F_BL8] ? 4'd8 : 4'd4;
   wire [7:0]  ref_limit   = ctrl_reg[`DDH_F_HOT] ? 8'(`DDH_TREFI_HOT_CYC)
                                                  : 8'(`DDH_TREFI_CYC);
   wire        do_write    = aw_got_reg && w_got_reg && !s_bvalid;
   wire        rd_take     = s_arvalid && s_arready;
   wire        wr_ctrl     = do_write && awaddr_reg == `DDH_OFF_CTRL;
   wire        wr_cmd      = do_write && awaddr_reg == `DDH_OFF_CMD && !cmd_pend_reg;
   wire        wr_addr     = do_write && awaddr_reg == `DDH_OFF_ADDR;
   wire        wr_mask     = do_write && awaddr_reg == `DDH_OFF_MASK;
   wire        wr_wdat     = do_write && awaddr_reg[7:4] == `DDH_OFF_WDAT && !awaddr_reg[1];
   wire        wr_known    = awaddr_reg[7:4] == `DDH_OFF_WDAT ||
                             awaddr_reg <= `DDH_OFF_STAT;
   wire [2:0]  wsel        = {awaddr_reg[3:2], 1'b0};
   wire [2:0]  rsel        = {s_araddr[3:2], 1'b0};
   wire        ls_edge     = (ls_s2 == ls_s3) && (ls_s3 != ls_f);
   wire        rd_beat     = state_reg == S_RBURST && ls_edge;
   wire        wr_beat     = state_reg == S_WBURST && dat_tick;
   wire        refresh_due = ref_pend_reg && ctrl_reg[`DDH_F_REFEN];
   wire        issue_ok    = tick && state_reg == S_IDLE;
   wire        take_cmd    = issue_ok && !refresh_due && cmd_pend_reg;
   wire [31:0] stat_word   = {23'h0, rd_done_reg, state_reg == S_SREF,
                              state_reg == S_PDOWN, open_reg, cmd_pend_reg, refresh_due};
   wire [31:0] mrs_addr    = addr_reg[14] ? addr_reg :
                             (addr_reg[13] ? {addr_reg[31:6], posted_command_delay,
                                              addr_reg[2:0]}
                                           : {addr_reg[31:7], column_read_delay,
                                              ctrl_reg[`DDH_F_ILV], 1'b0,
                                              ctrl_reg[`DDH_F_BL8], ~ctrl_reg[`DDH_F_BL8]});
   wire [2:0]  crd_w       = (wdata_reg[2:0] < 3'd4) ? 3'd4 : wdata_reg[2:0];
   wire [2:0]  pcd_w       = (wdata_reg[6:4] > 3'd5) ? 3'd5 : wdata_reg[6:4];

   function automatic logic [31:0] ddh_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : ddh_merge

   // Register slave: address and data are taken in either order.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h0;
         wstrb_reg  <= 4'h0;
         s_bvalid   <= 1'b0;
         s_bresp    <= 2'b00;
         s_rvalid   <= 1'b0;
         s_rdata    <= 32'h0;
         s_rresp    <= 2'b00;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_wdata;
            wstrb_reg <= s_wstrb;
         end
         if (do_write) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            s_bvalid   <= 1'b1;
            s_bresp    <= wr_known ? 2'b00 : 2'b10;
         end else if (s_bready) begin
            s_bvalid <= 1'b0;
         end
         if (rd_take) begin
            s_rvalid <= 1'b1;
            s_rresp  <= 2'b00;
            case (s_araddr)
               `DDH_OFF_CTRL: s_rdata <= ctrl_reg;
               `DDH_OFF_CMD:  s_rdata <= {28'h0, op_reg};
               `DDH_OFF_ADDR: s_rdata <= addr_reg;
               `DDH_OFF_MASK: s_rdata <= mask_reg;
               `DDH_OFF_STAT: s_rdata <= stat_word;
               default: begin
                  if (s_araddr[7:4] == `DDH_OFF_WDAT) begin
                     s_rdata <= {wbuf[rsel + 3'd1], wbuf[rsel]};
                  end else if (s_araddr[7:4] == `DDH_OFF_RDAT) begin
                     s_rdata <= {rbuf[rsel + 3'd1], rbuf[rsel]};
                  end else begin
                     s_rdata <= 32'h0;
                     s_rresp <= 2'b10;
                  end
               end
            endcase
         end else if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   assign s_awready = !aw_got_reg && rst_n;
   assign s_wready  = !w_got_reg && rst_n;
   assign s_arready = !s_rvalid && rst_n;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg     <= `DDH_CTRL_RST;
         addr_reg     <= 32'h0;
         mask_reg     <= 32'h0;
         op_reg       <= 4'h0;
         cmd_pend_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= ddh_merge(ctrl_reg, {wdata_reg[31:7], pcd_w, 1'b0, crd_w}, wstrb_reg);
         end
         if (wr_addr) begin
            addr_reg <= ddh_merge(addr_reg, wdata_reg, wstrb_reg);
         end
         if (wr_mask) begin
            mask_reg <= ddh_merge(mask_reg, wdata_reg, wstrb_reg);
         end
         if (wr_cmd) begin
            op_reg       <= wdata_reg[3:0];
            cmd_pend_reg <= 1'b1;
         end else if (take_cmd || (tick && cmd_pend_reg && op_reg == `DDH_OP_EXIT &&
                                   (state_reg == S_PDOWN || state_reg == S_SREF))) begin
            cmd_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_wdat) begin
         wbuf[wsel]        <= wdata_reg[15:0];
         wbuf[wsel + 3'd1] <= wdata_reg[31:16];
      end
      if (state_reg == S_RBURST && ls_edge) begin
         rbuf[beat_reg[2:0]] <= dq_s3;
      end
   end

   // Link clock: four core cycles per period, pins change while the clock is low.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg         <= 2'd0;
         diff_clock_pair_p <= 1'b0;
         diff_clock_pair_n <= 1'b1;
      end else begin
         phase_reg         <= phase_reg + 2'd1;
         diff_clock_pair_p <= phase_reg[0] ^ phase_reg[1];
         diff_clock_pair_n <= ~(phase_reg[0] ^ phase_reg[1]);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ls_s1 <= 1'b0;
         ls_s2 <= 1'b0;
         ls_s3 <= 1'b0;
         ls_f  <= 1'b0;
         dq_s1 <= 16'h0;
         dq_s2 <= 16'h0;
         dq_s3 <= 16'h0;
      end else begin
         ls_s1 <= lower_byte_strobe_i;
         ls_s2 <= ls_s1;
         ls_s3 <= ls_s2;
         dq_s1 <= dq_i;
         dq_s2 <= dq_s1;
         dq_s3 <= dq_s2;
         if (ls_s2 == ls_s3) begin
            ls_f <= ls_s3;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_reg  <= 8'h0;
         ref_pend_reg <= 1'b0;
      end else begin
         ref_cnt_reg  <= (ref_cnt_reg >= ref_limit - 8'd1) ? 8'h0 : ref_cnt_reg + 8'd1;
         ref_pend_reg <= (ref_cnt_reg >= ref_limit - 8'd1) ||
                         (ref_pend_reg && !(issue_ok && open_reg == 4'h0));
      end
   end

   // Command sequencer; every pin update lands on the falling half of the link clock.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= S_IDLE;
         pins         <= '{clock_enable: 1'b1, chip_select_n: 1'b1, strobes_n: `DDH_PIN_NOP,
                           default: '0};
         lat_reg      <= 4'h0;
         beat_reg     <= 4'h0;
         open_reg     <= 4'h0;
         rd_done_reg  <= 1'b0;
         sr_issue_reg <= 1'b0;
      end else if (tick && !rd_beat && !wr_beat) begin
         pins.chip_select_n <= 1'b1;
         pins.strobes_n     <= `DDH_PIN_NOP;
         pins.termination_control <= ctrl_reg[`DDH_F_TERM] &&
                                     (state_reg == S_WLAT || state_reg == S_WBURST);
         case (state_reg)
            S_IDLE: begin
               if (refresh_due) begin
                  pins.chip_select_n  <= 1'b0;
                  pins.addr           <= 13'h1 << `DDH_SCOPE_BIT;
                  pins.strobes_n      <= (open_reg != 4'h0) ? `DDH_PIN_PRE : `DDH_PIN_REF;
                  open_reg            <= 4'h0;
               end else if (cmd_pend_reg) begin
                  pins.chip_select_n <= 1'b0;
                  pins.bank_select   <= addr_reg[14:13];
                  pins.addr          <= addr_reg[12:0];
                  case (op_reg)
                     `DDH_OP_ACT: begin
                        pins.strobes_n <= `DDH_PIN_ACT;
                        open_reg[addr_reg[14:13]] <= 1'b1;
                     end
                     `DDH_OP_RD, `DDH_OP_WR: begin
                        pins.strobes_n <= (op_reg == `DDH_OP_RD) ? `DDH_PIN_RD : `DDH_PIN_WR;
                        pins.addr      <= {4'h0, addr_reg[8:0]};
                        lat_reg        <= (op_reg == `DDH_OP_RD) ? read_delay : write_delay;
                        state_reg      <= (op_reg == `DDH_OP_RD) ? S_RLAT : S_WLAT;
                        rd_done_reg    <= rd_done_reg && op_reg != `DDH_OP_RD;
                        beat_reg       <= 4'h0;
                     end
                     `DDH_OP_PRE: begin
                        pins.strobes_n <= `DDH_PIN_PRE;
                        if (addr_reg[`DDH_SCOPE_BIT]) begin
                           open_reg <= 4'h0;
                        end else begin
                           open_reg[addr_reg[14:13]] <= 1'b0;
                        end
                     end
                     `DDH_OP_REF: begin
                        pins.strobes_n     <= (open_reg == 4'h0) ? `DDH_PIN_REF : `DDH_PIN_NOP;
                        pins.chip_select_n <= open_reg != 4'h0;
                     end
                     `DDH_OP_MRS: begin
                        pins.strobes_n <= `DDH_PIN_MRS;
                        pins.addr      <= mrs_addr[12:0];
                     end
                     `DDH_OP_PD: begin
                        pins.chip_select_n <= 1'b1;
                        pins.clock_enable  <= 1'b0;
                        state_reg          <= S_PDOWN;
                     end
                     `DDH_OP_SR: begin
                        pins.strobes_n     <= (open_reg == 4'h0) ? `DDH_PIN_REF : `DDH_PIN_NOP;
                        pins.chip_select_n <= open_reg != 4'h0;
                        pins.clock_enable  <= open_reg != 4'h0;
                        state_reg          <= (open_reg == 4'h0) ? S_SREF : S_IDLE;
                        sr_issue_reg       <= open_reg == 4'h0;
                     end
                     default: begin
                        pins.chip_select_n <= 1'b1;
                     end
                  endcase
               end
            end
            S_WLAT, S_RLAT: begin
               lat_reg <= lat_reg - 4'd1;
               if (lat_reg <= 4'd1) begin
                  state_reg <= (state_reg == S_WLAT) ? S_WBURST : S_RBURST;
               end
            end
            S_PDOWN, S_SREF: begin
               sr_issue_reg <= 1'b0;
               if (cmd_pend_reg && op_reg == `DDH_OP_EXIT) begin
                  pins.clock_enable <= 1'b1;
                  state_reg         <= S_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (state_reg == S_RBURST && ls_edge) begin
         beat_reg <= beat_reg + 4'd1;
         if (beat_reg == burst_words - 4'd1) begin
            state_reg   <= S_IDLE;
            rd_done_reg <= 1'b1;
         end
      end else if (state_reg == S_WBURST && dat_tick && beat_reg == burst_words) begin
         state_reg <= S_IDLE;
      end else if (state_reg == S_WBURST && dat_tick) begin
         beat_reg <= beat_reg + 4'd1;
      end
   end

   // Write data lanes: words change on the clock, strobes toggle midway between.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_o                <= 16'h0;
         dq_oe               <= 1'b0;
         strobe_oe           <= 1'b0;
         lower_byte_strobe_o <= 1'b0;
         upper_byte_strobe_o <= 1'b0;
         write_byte_mask     <= 2'b00;
      end else begin
         if (dat_tick) begin
            dq_oe           <= state_reg == S_WBURST && beat_reg < burst_words;
            dq_o            <= wbuf[beat_reg[2:0]];
            write_byte_mask <= mask_reg[2*beat_reg[2:0] +: 2];
            strobe_oe       <= state_reg == S_WBURST && beat_reg < burst_words;
         end
         if (stb_tick) begin
            lower_byte_strobe_o <= dq_oe && !lower_byte_strobe_o;
            upper_byte_strobe_o <= dq_oe && !upper_byte_strobe_o;
         end
      end
   end

   // Checks.
   property p_cke_access;
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg inside {S_WLAT, S_WBURST, S_RLAT, S_RBURST}) |-> pins.clock_enable;
   endproperty
   a_cke_access: assert property (p_cke_access) else $error("Enable low in access.");
   property p_strobe_data;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(dq_oe) |=> strobe_oe && lower_byte_strobe_o && upper_byte_strobe_o;
   endproperty
   a_strobe_data: assert property (p_strobe_data) else $error("Data without strobe.");
   property p_ref_bound;
      @(posedge core_clk) disable iff (!rst_n) ref_cnt_reg < ref_limit;
   endproperty
   a_ref_bound: assert property (p_ref_bound) else $error("Refresh count overrun.");
   property p_latency;
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == S_IDLE && take_cmd && op_reg == `DDH_OP_WR) |=> lat_reg == write_delay;
   endproperty
   a_latency: assert property (p_latency) else $error("Write delay wrong.");
   property p_crd_range;
      @(posedge core_clk) disable iff (!rst_n)
      column_read_delay >= 3'd4 && posted_command_delay <= 3'd5;
   endproperty
   a_crd_range: assert property (p_crd_range) else $error("Latency out of range.");
   property p_prech_all;
      @(posedge core_clk) disable iff (!rst_n)
      (take_cmd && op_reg == `DDH_OP_PRE && addr_reg[`DDH_SCOPE_BIT]) |=> open_reg == 4'h0;
   endproperty
   a_prech_all: assert property (p_prech_all) else $error("Banks left open.");
   property p_pd_cke;
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == S_PDOWN) ##1 (state_reg == S_PDOWN) |-> !pins.clock_enable;
   endproperty
   a_pd_cke: assert property (p_pd_cke) else $error("Enable high in power-down.");
   property p_burst_len;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(dq_oe) |-> beat_reg == burst_words;
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("Burst length wrong.");
   c_write: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(dq_oe));
   c_read: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(rd_done_reg));
   c_sref: cover property (@(posedge core_clk) disable iff (!rst_n) state_reg == S_SREF);
endmodule : ddh_ctrl

// ==== verification/ddh_dev_model.sv ====
`timescale 1ns/1ps
module ddh_dev_model (
   input  wire logic               ck_p,
   input  wire ddh_pkg::ddh_pins_t pins,
   input  wire logic [15:0]        dq_o,
   input  wire logic               strobe_oe,
   input  wire logic               lstrobe_o,
   input  wire logic [1:0]         mask,
   input  wire logic [3:0]         rl,
   output logic [15:0]             dq_dev,
   output logic                    lstrobe_dev
);
   import ddh_pkg::*;
   logic [15:0] mem [0:7];
   int          wi;
   logic        term_on = 1'b0;
   localparam bit term_allowed = 1'b1;
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
      wi = 0;
      dq_dev = 16'h5a5a;
      lstrobe_dev = 1'b0;
   end
   // Read words follow the read delay, one per clock crossing, strobe edge-aligned.
   task automatic read_burst();
      repeat (rl) @(posedge ck_p);
      for (int i = 0; i < 4; i++) begin
         dq_dev = mem[i];
         lstrobe_dev = ~lstrobe_dev;
         @(ck_p);
      end
      dq_dev = ~dq_dev;
   endtask : read_burst
   // Commands latch at the rising crossing, only with clock enable and select.
   always @(posedge ck_p) begin
      // Termination follows its input while clock enable is high, unless term_allowed is cleared.
      term_on = pins.clock_enable && pins.termination_control && term_allowed;
      if (pins.clock_enable && !pins.chip_select_n) begin
         if (pins.strobes_n == 3'h4) wi = 0;
         if (pins.strobes_n == 3'h5) read_burst();
      end
   end
   // Each writer strobe edge takes a word; a high mask keeps its byte.
   always @(lstrobe_o) begin
      if (strobe_oe && wi < 8) begin
         if (!mask[0]) mem[wi][7:0] = dq_o[7:0];
         if (!mask[1]) mem[wi][15:8] = dq_o[15:8];
         wi++;
      end
   end
endmodule : ddh_dev_model

// ==== verification/test_ddh_ctrl.sv ====
`timescale 1ns/1ps
module test_ddh_ctrl;
   import ddh_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata, d;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ck_p, ck_n, dq_oe, s_oe, ls_o, ls_d;
   logic [1:0] s_bresp, s_rresp, wmask, r;
   logic [15:0] dq_o, dq_dev;
   ddh_pins_t pins;
   int checks = 0, fails = 0, cyc = 0;
   logic term_seen = 1'b0;
   always @(posedge core_clk) if (i_dev.term_on) term_seen <= 1'b1;
   always #25 core_clk = ~core_clk;
   ddh_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .diff_clock_pair_p(ck_p), .diff_clock_pair_n(ck_n), .pins(pins), .dq_o(dq_o),
      .dq_oe(dq_oe), .dq_i(dq_dev), .lower_byte_strobe_o(ls_o), .upper_byte_strobe_o(),
      .strobe_oe(s_oe), .lower_byte_strobe_i(ls_d), .write_byte_mask(wmask));
   ddh_dev_model i_dev (.ck_p(ck_p), .pins(pins), .dq_o(dq_o), .strobe_oe(s_oe),
      .lstrobe_o(ls_o), .mask(wmask), .rl(4'h4), .dq_dev(dq_dev), .lstrobe_dev(ls_d));
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (s_awvalid || s_wvalid || !s_bvalid) begin
         @(posedge core_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end
      r = s_bresp;
      s_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      while (s_arvalid || !s_rvalid) begin
         @(posedge core_clk);
         if (s_arready) s_arvalid <= 1'b0;
      end
      d = s_rdata;
      s_rready <= 1'b0;
   endtask : rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Polls the status word until one bit reaches a level, then compares it.
   task automatic poll(input int b, input logic v);
      for (int i = 0; i < 300; i++) begin
         rd(8'h10);
         if (d[b] === v) break;
      end
      chk({31'h0, d[b]}, {31'h0, v});
   endtask : poll
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(8'h00);
      chk(d, 32'h0000_4004);
      wr(8'h00, 32'h0000_4003);
      rd(8'h00);
      chk(d, 32'h0000_4004);
      wr(8'h00, 32'h0000_4077);
      rd(8'h00);
      chk(d, 32'h0000_4057);
      wr(8'hf0, 32'h1);
      chk({30'h0, r}, 32'h2);
      wr(8'h00, 32'h0000_5004);
      wr(8'h08, 32'h0000_0000);
      wr(8'h04, 32'h6);
      poll(1, 1'b0);
      wr(8'h20, 32'h2222_1111);
      wr(8'h24, 32'h4444_3333);
      wr(8'h0c, 32'h0000_0004);
      wr(8'h08, 32'h0000_2010);
      wr(8'h04, 32'h1);
      poll(3, 1'b1);
      wr(8'h04, 32'h3);
      poll(1, 1'b0);
      repeat (60) @(posedge core_clk);
      chk({31'h0, term_seen}, 32'h1);
      wr(8'h04, 32'h2);
      poll(8, 1'b1);
      chk({31'h0, pins.termination_control}, 32'h0);
      rd(8'h30);
      chk(d, 32'h2200_1111);
      rd(8'h34);
      chk(d, 32'h4444_3333);
      wr(8'h08, 32'h0000_0400);
      wr(8'h04, 32'h4);
      poll(3, 1'b0);
      wr(8'h04, 32'h7);
      poll(6, 1'b1);
      chk({31'h0, pins.clock_enable}, 32'h0);
      wr(8'h04, 32'h9);
      poll(6, 1'b0);
      wr(8'h04, 32'h8);
      poll(7, 1'b1);
      chk({31'h0, pins.clock_enable}, 32'h0);
      wr(8'h04, 32'h9);
      poll(7, 1'b0);
      summarize();
   end
endmodule : test_ddh_ctrl
